// ===== rtl/scb_pkg.sv
// How it works
// - Single mode: write sets, shift load clears TX-full
// - FIFO mode: TX-full while all locations used
// - Single mode: capture sets, read clears RX-full
// - FIFO mode: RX-full while all locations unread
// - Width select: 16 bits set, 8 clear
// - Sample phase: end or middle of bit
// - Framed mode ignores clock edge select
// - Idle polarity sets clock idle level
// - Role select: master makes clock, else slave
// - Secondary divider 1..8, code 111 is 1
// - Primary divider 1,4,16,64 for 11..00
// - Serial clock is instruction clock over product
// - Framed enable drives select pin as sync pulse output while frame direction is clear; the pin input is never read
// - Frame direction: input when set, output clear
// - Frame pulse polarity high when set
// - Frame edge: with first bit, or one before in master mode only
// - Buffer enable selects FIFO mode
// - FIFO has eight levels, single has one
package scb_pkg;
	// ****************************************
	// Register map, word addresses
	// ****************************************
	localparam logic [1:0] ADDR_STATUS = 2'h0;
	localparam logic [1:0] ADDR_CTRL1 = 2'h1;
	localparam logic [1:0] ADDR_CTRL2 = 2'h2;
	localparam logic [1:0] ADDR_DATA = 2'h3;
	localparam logic [15:0] CTRL1_RESET = 16'h0000;
	localparam logic [15:0] CTRL2_RESET = 16'h0000;
	localparam logic [15:0] CTRL1_MASK = 16'h1FFF;
	localparam logic [15:0] CTRL2_MASK = 16'hE003;
	localparam logic [15:0] STAT_MASK = 16'hA01C;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int B_EN = 15;
	localparam int B_SRMPT = 7;
	localparam int B_ROV = 6;
	localparam int B_RXMPT = 5;
	localparam int B_TBF = 1;
	localparam int B_RBF = 0;
	localparam int B_DISSCLK = 12;
	localparam int B_DISOUT = 11;
	localparam int B_WIDE = 10;
	localparam int B_SMPPH = 9;
	localparam int B_EDGE = 8;
	localparam int B_SELEN = 7;
	localparam int B_IDLE = 6;
	localparam int B_MASTER = 5;
	localparam int B_FRAME = 15;
	localparam int B_FDIR = 14;
	localparam int B_FPOL = 13;
	localparam int B_FEDGE = 1;
	localparam int B_FIFOEN = 0;
	// ****************************************
	// Buffering and counts
	// ****************************************
	localparam int FIFO_DEPTH = 8;
	localparam int PTR_W = 3;
	localparam logic [3:0] CNT_FULL = 4'h8;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [4:0] BITS_WIDE = 5'h10;
	localparam logic [4:0] BITS_BYTE = 5'h08;
	localparam logic [7:0] DIV_ONE = 8'h01;
	typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_DONE} scb_state_type;
endpackage : scb_pkg

// ===== rtl/scb_clkdiv.sv
`timescale 1ns/1ns
// ****************************************
// Two-stage prescaler, one tick per half bit
// ****************************************
module scb_clkdiv
	import scb_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Control
	input wire logic run,
	input wire logic [1:0] primary_divider,
	input wire logic [2:0] secondary_divider,
	// Tick
	output logic tick
);
	// Ten bits: the largest product, 64 times 8, overflows a byte
	logic [9:0] cnt_ff;
	logic [9:0] ratio;
	logic [9:0] pri;
	logic [9:0] sec;

	always_comb begin
		case (primary_divider)
			2'h3: pri = 10'h001;
			2'h2: pri = 10'h004;
			2'h1: pri = 10'h010;
			default: pri = 10'h040;
		endcase
		sec = 10'(4'h8 - {1'b0, secondary_divider});
		ratio = 10'(pri * sec);
	end

	// One tick per ratio cycles, two per bit: clk_sys runs at twice the instruction clock
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 10'h000;
			tick <= 1'b0;
		end else if (!run) begin
			cnt_ff <= 10'h000;
			tick <= 1'b0;
		end else if (cnt_ff + 10'(DIV_ONE) >= ratio) begin
			cnt_ff <= 10'h000;
			tick <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 10'(DIV_ONE);
			tick <= 1'b0;
		end
	end
endmodule : scb_clkdiv

// ===== rtl/scb_spi.sv
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
module scb_spi
	import scb_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Serial clock pin
	input wire logic serial_clock_pin_i,
	output logic serial_clock_pin_o,
	output logic serial_clock_pin_oe,
	// Serial data
	input wire logic serial_in_pin,
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe,
	// Select or frame pin
	input wire logic select_frame_pin_i,
	output logic select_frame_pin_o,
	output logic select_frame_pin_oe
);
	// ****************************************
	// Registers
	// ****************************************
	logic [15:0] ctrl1_ff;
	logic [15:0] ctrl2_ff;
	logic [15:0] stat_ff;
	logic ack_ff;
	logic rov_ff;
	logic [15:0] tx_mem [FIFO_DEPTH];
	logic [15:0] rx_mem [FIFO_DEPTH];
	logic [PTR_W-1:0] tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff;
	logic [3:0] tx_cnt_ff, rx_cnt_ff;
	logic [15:0] shift_ff;
	logic [4:0] bit_cnt_ff;
	logic phase_ff;
	logic sck_prev_ff;
	logic in_bit_ff;
	scb_state_type state_ff;
	logic tick;
	logic enabled, master, fifo, wide, framed, cpol;
	logic [3:0] cap;
	logic wr_data, rd_data, load, done, run;
	logic [4:0] nbits;

	assign enabled = stat_ff[B_EN];
	assign master = ctrl1_ff[B_MASTER];
	assign fifo = ctrl2_ff[B_FIFOEN];
	assign wide = ctrl1_ff[B_WIDE];
	assign framed = ctrl2_ff[B_FRAME];
	assign cpol = ctrl1_ff[B_IDLE];
	assign cap = fifo ? CNT_FULL : CNT_ONE;
	assign nbits = wide ? BITS_WIDE : BITS_BYTE;
	assign wr_data = avs_write && !ack_ff && avs_address == ADDR_DATA;
	assign rd_data = avs_read && !ack_ff && avs_address == ADDR_DATA;
	assign load = state_ff == ST_IDLE && enabled && tx_cnt_ff != 4'h0;
	assign done = state_ff == ST_DONE;
	assign run = enabled && master && state_ff != ST_IDLE;

	function automatic logic [15:0] width_mask(input logic w);
		width_mask = w ? 16'hFFFF : 16'h00FF;
	endfunction : width_mask

	// ****************************************
	// Avalon slave: one wait cycle per access
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (avs_read || avs_write) && !ack_ff;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && !ack_ff);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !ack_ff) begin
			case (avs_address)
				ADDR_STATUS: avs_readdata <= {16'h0000, stat_ff};
				ADDR_CTRL1: avs_readdata <= {16'h0000, ctrl1_ff};
				ADDR_CTRL2: avs_readdata <= {16'h0000, ctrl2_ff};
				default: avs_readdata <= {16'h0000, rx_mem[rx_rp_ff] & width_mask(wide)};
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1_ff <= CTRL1_RESET;
			ctrl2_ff <= CTRL2_RESET;
		end else if (avs_write && !ack_ff) begin
			if (avs_address == ADDR_CTRL1)
				ctrl1_ff <= avs_writedata[15:0] & CTRL1_MASK;
			if (avs_address == ADDR_CTRL2)
				ctrl2_ff <= avs_writedata[15:0] & CTRL2_MASK;
		end
	end

	// Overflow: set wins over a software clear in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rov_ff <= 1'b0;
		end else if (done && rx_cnt_ff == cap) begin
			rov_ff <= 1'b1;
		end else if (avs_write && !ack_ff && avs_address == ADDR_STATUS && !avs_writedata[B_ROV]) begin
			rov_ff <= 1'b0;
		end
	end

	// ****************************************
	// Status word, flags follow buffer counts
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stat_ff <= 16'h0000;
		end else begin
			if (avs_write && !ack_ff && avs_address == ADDR_STATUS)
				stat_ff[B_EN] <= avs_writedata[B_EN];
			stat_ff[14:8] <= fifo ? 7'(master ? tx_cnt_ff : rx_cnt_ff) : 7'h00;
			stat_ff[B_SRMPT] <= state_ff == ST_IDLE;
			stat_ff[B_ROV] <= rov_ff;
			stat_ff[B_RXMPT] <= rx_cnt_ff == 4'h0;
			stat_ff[4:2] <= 3'h0;
			stat_ff[B_TBF] <= tx_cnt_ff == cap;
			stat_ff[B_RBF] <= rx_cnt_ff == cap;
		end
	end

	// ****************************************
	// Transmit buffer
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_wp_ff <= '0;
			tx_rp_ff <= '0;
			tx_cnt_ff <= 4'h0;
		end else begin
			if (wr_data && tx_cnt_ff != cap) begin
				tx_mem[tx_wp_ff] <= avs_writedata[15:0] & width_mask(wide);
				tx_wp_ff <= fifo ? tx_wp_ff + 1'b1 : tx_wp_ff;
			end
			if (load)
				tx_rp_ff <= fifo ? tx_rp_ff + 1'b1 : tx_rp_ff;
			tx_cnt_ff <= 4'(tx_cnt_ff + (wr_data && tx_cnt_ff != cap) - load);
		end
	end

	// ****************************************
	// Receive buffer, new word dropped when full
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_wp_ff <= '0;
			rx_rp_ff <= '0;
			rx_cnt_ff <= 4'h0;
		end else begin
			if (done && rx_cnt_ff != cap) begin
				rx_mem[rx_wp_ff] <= shift_ff & width_mask(wide);
				rx_wp_ff <= fifo ? rx_wp_ff + 1'b1 : rx_wp_ff;
			end
			if (rd_data && rx_cnt_ff != 4'h0)
				rx_rp_ff <= fifo ? rx_rp_ff + 1'b1 : rx_rp_ff;
			rx_cnt_ff <= 4'(rx_cnt_ff + (done && rx_cnt_ff != cap)
				- (rd_data && rx_cnt_ff != 4'h0));
		end
	end

	// ****************************************
	// Shifter
	// ****************************************
	scb_clkdiv u_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.run(run),
		.primary_divider(ctrl1_ff[1:0]),
		.secondary_divider(ctrl1_ff[4:2]),
		.tick(tick)
	);

	// Slave clock edges; pins are synchronous per system integration
	logic sck_in, lead_edge, trail_edge, m_lead, m_trail, sample_now, shift_now, edge_sel;
	assign sck_in = serial_clock_pin_i ^ cpol;
	assign lead_edge = sck_in && !sck_prev_ff;
	assign trail_edge = !sck_in && sck_prev_ff;
	assign m_lead = tick && !phase_ff;
	assign m_trail = tick && phase_ff;
	assign edge_sel = ctrl1_ff[B_EDGE] && !framed;
	// Edge select set, slave unframed only: data changes on leading edge, sampled on trailing
	assign sample_now = master ? (ctrl1_ff[B_SMPPH] ? m_trail : m_lead)
		: (edge_sel ? trail_edge : lead_edge);
	assign shift_now = master ? m_trail : (edge_sel ? lead_edge : trail_edge);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sck_prev_ff <= 1'b0;
		end else begin
			sck_prev_ff <= sck_in;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			shift_ff <= 16'h0000;
			bit_cnt_ff <= 5'h00;
			phase_ff <= 1'b0;
			in_bit_ff <= 1'b0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					phase_ff <= 1'b0;
					bit_cnt_ff <= 5'h00;
					if (load) begin
						shift_ff <= tx_mem[tx_rp_ff] << (wide ? 5'h00 : BITS_BYTE);
						state_ff <= (master && framed && !ctrl2_ff[B_FEDGE]) ? ST_LEAD : ST_SHIFT;
					end
				end
				ST_LEAD: if (tick) begin
					phase_ff <= !phase_ff;
					if (phase_ff)
						state_ff <= ST_SHIFT;
				end
				ST_SHIFT: begin
					if (master && tick)
						phase_ff <= !phase_ff;
					if (sample_now)
						in_bit_ff <= serial_in_pin;
					if (shift_now) begin
						shift_ff <= {shift_ff[14:0], sample_now ? serial_in_pin : in_bit_ff};
						bit_cnt_ff <= bit_cnt_ff + 5'h01;
						if (bit_cnt_ff + 5'h01 == nbits)
							state_ff <= ST_DONE;
					end
				end
				ST_DONE: state_ff <= ST_IDLE;
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// Pins
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			serial_clock_pin_o <= 1'b0;
			serial_clock_pin_oe <= 1'b0;
			serial_out_pin_o <= 1'b0;
			serial_out_pin_oe <= 1'b0;
			select_frame_pin_o <= 1'b0;
			select_frame_pin_oe <= 1'b0;
		end else begin
			serial_clock_pin_o <= cpol ^ (state_ff == ST_SHIFT && phase_ff);
			serial_clock_pin_oe <= enabled && master && !ctrl1_ff[B_DISSCLK];
			serial_out_pin_o <= shift_ff[15];
			serial_out_pin_oe <= enabled && !ctrl1_ff[B_DISOUT];
			// Pulse spans lead period or first bit, set by edge bit
			select_frame_pin_o <= ctrl2_ff[B_FPOL] ~^ (state_ff == ST_LEAD
				|| (state_ff == ST_SHIFT && bit_cnt_ff == 5'h00 && ctrl2_ff[B_FEDGE]));
			select_frame_pin_oe <= enabled && framed && !ctrl2_ff[B_FDIR];
		end
	end
endmodule : scb_spi

// ===== dv/scb_slave_model.sv
`timescale 1ns/1ns
// ****
// Echoing serial slave
// ****
module scb_slave_model (
	// System
	input wire logic clk_sys,
	input wire logic rst_n,
	// Serial lines
	input wire logic sck,
	input wire logic sdo,
	input wire logic sdo_oe,
	output logic sdi,
	// Measures
	output int rises,
	output int period
);
	logic sck_q;
	logic last_q;
	int gap;
	// Released line shows the inverse, so a stale copy cannot pass
	assign sdi = sdo_oe ? sdo : ~last_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sck_q <= 1'b0;
			last_q <= 1'b0;
			gap <= 0;
			rises <= 0;
			period <= 0;
		end else begin
			sck_q <= sck;
			gap <= gap + 1;
			if (sdo_oe)
				last_q <= sdo;
			if (sck && !sck_q) begin
				rises <= rises + 1;
				period <= gap + 1;
				gap <= 0;
			end
		end
	end
endmodule : scb_slave_model

// ===== dv/scb_spi_assertions.sv
`timescale 1ns/1ns
// ****
// Port checker
// ****
module scb_spi_chk
	import scb_pkg::*;
(
	// System
	input wire logic clk_sys,
	input wire logic rst_n,
	// Register bus
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Pins
	input wire logic serial_clock_pin_o,
	input wire logic serial_clock_pin_oe,
	input wire logic serial_out_pin_oe,
	input wire logic select_frame_pin_oe
);
	logic [15:0] c1_ff;
	logic [15:0] c2_ff;
	logic en_ff;
	logic [1:0] quiet_ff;
	wire logic wr_ok = avs_write && !avs_waitrequest;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			c1_ff <= CTRL1_RESET;
			c2_ff <= CTRL2_RESET;
			en_ff <= 1'b0;
		end else if (wr_ok) begin
			if (avs_address == ADDR_CTRL1)
				c1_ff <= avs_writedata[15:0] & CTRL1_MASK;
			if (avs_address == ADDR_CTRL2)
				c2_ff <= avs_writedata[15:0] & CTRL2_MASK;
			if (avs_address == ADDR_STATUS)
				en_ff <= avs_writedata[B_EN];
		end
	end
	// Pin enables lag a write; judge them once settled
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			quiet_ff <= 2'h0;
		else if (wr_ok)
			quiet_ff <= 2'h0;
		else if (quiet_ff != 2'h3)
			quiet_ff <= quiet_ff + 2'h1;
	end
	sequence s_req;
		$rose(avs_read || avs_write);
	endsequence
	sequence s_ack;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	a_bus_answer: assert property (s_req |=> s_ack) else $error("bus answer late or long");
	a_bus_quiet: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("accept without request");
	a_ctrl1_read: assert property (avs_read && !avs_waitrequest && avs_address == ADDR_CTRL1
		|-> avs_readdata == {16'h0000, c1_ff}) else $error("ctrl1 readback");
	a_ctrl2_read: assert property (avs_read && !avs_waitrequest && avs_address == ADDR_CTRL2
		|-> avs_readdata == {16'h0000, c2_ff}) else $error("ctrl2 readback");
	a_sck_drive: assert property (quiet_ff == 2'h3 |-> serial_clock_pin_oe ==
		(en_ff && c1_ff[B_MASTER] && !c1_ff[B_DISSCLK])) else $error("clock pin enable");
	a_sdo_drive: assert property (quiet_ff == 2'h3 |-> serial_out_pin_oe ==
		(en_ff && !c1_ff[B_DISOUT])) else $error("data pin enable");
	a_frame_drive: assert property (quiet_ff == 2'h3 |-> select_frame_pin_oe ==
		(en_ff && c2_ff[B_FRAME] && !c2_ff[B_FDIR])) else $error("frame pin enable");
	a_idle_level: assert property ($rose(serial_clock_pin_oe)
		|-> serial_clock_pin_o == c1_ff[B_IDLE]) else $error("clock idle level");
endmodule : scb_spi_chk
bind scb_spi scb_spi_chk scb_spi_chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .serial_clock_pin_o(serial_clock_pin_o),
	.serial_clock_pin_oe(serial_clock_pin_oe), .serial_out_pin_oe(serial_out_pin_oe),
	.select_frame_pin_oe(select_frame_pin_oe));

// ===== dv/test_scb_spi.sv
`timescale 1ns/1ns
module test_scb_spi
	import scb_pkg::*;
;
	logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, frame_in;
	logic sck_o, sck_oe, sdo, sdo_oe, fs_o, fs_oe, sdi;
	logic [1:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [15:0] exp_q[$], msk_q[$], d, r;
	int errors, num_checks, seed, cycles, rises, period;
	// Board pull-down on the clock line
	wire logic sck_w = sck_oe ? sck_o : 1'b0;
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	scb_spi scb_spi_i (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe),
		.serial_in_pin(sdi), .serial_out_pin_o(sdo), .serial_out_pin_oe(sdo_oe),
		.select_frame_pin_i(frame_in), .select_frame_pin_o(fs_o), .select_frame_pin_oe(fs_oe));
	scb_slave_model scb_slave_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .sck(sck_w),
		.sdo(sdo), .sdo_oe(sdo_oe), .sdi(sdi), .rises(rises), .period(period));
	// ****
	// Tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	task automatic bus(input logic [1:0] a, input logic w, input logic [15:0] v);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {16'h0000, v};
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		r = avs_readdata[15:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask : bus
	task automatic rd(input logic [1:0] a, input logic [15:0] e, input logic [15:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus(a, 1'b0, 16'h0000);
	endtask : rd
	task automatic take(input logic [15:0] v, input logic [15:0] m);
		do rd(ADDR_STATUS, 16'h0000, 16'h0000); while (r[B_RBF] !== 1'b1);
		rd(ADDR_DATA, v, m);
		rd(ADDR_STATUS, 16'h0000, 16'h0001);
	endtask : take
	task automatic xfer(input logic [15:0] c, input logic [15:0] v);
		int b;
		bus(ADDR_CTRL1, 1'b1, c);
		// Let an idle-level change reach the model before counting
		@(posedge clk_sys);
		b = rises;
		bus(ADDR_DATA, 1'b1, v);
		take(v, c[B_WIDE] ? 16'hFFFF : 16'h00FF);
		chk(rises - b, c[B_WIDE] ? 16 : 8);
	endtask : xfer
	// Read results are judged as they appear, oldest note first
	always @(posedge clk_sys) begin
		logic [15:0] m;
		if (avs_read && !avs_waitrequest && exp_q.size() > 0) begin
			m = msk_q.pop_front();
			chk(avs_readdata & {16'hFFFF, m}, {16'h0000, exp_q.pop_front() & m});
		end
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 80000) begin
			errors++;
			report_and_stop();
		end
	end
	// ****
	// Sequence
	// ****
	initial begin
		seed = 85378;
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 2'h0;
		avs_writedata = 32'h0;
		frame_in = 1'b1;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rd(ADDR_CTRL1, CTRL1_RESET, 16'hFFFF);
		rd(ADDR_CTRL2, CTRL2_RESET, 16'hFFFF);
		rd(ADDR_STATUS, 16'h0000, 16'h8003);
		$display("reset test done");
		bus(ADDR_STATUS, 1'b1, 16'h8000);
		repeat (8) begin
			d = 16'($random(seed));
			d[B_FEDGE - 1] = 1'b0;
			d[B_EDGE] = 1'b0;
			if (!d[B_MASTER])
				d[B_SMPPH] = 1'b0;
			frame_in <= d[15];
			bus(ADDR_CTRL1, 1'b1, d);
			rd(ADDR_CTRL1, d & CTRL1_MASK, 16'hFFFF);
			d = 16'($random(seed));
			bus(ADDR_CTRL2, 1'b1, d);
			rd(ADDR_CTRL2, d & CTRL2_MASK, 16'hFFFF);
		end
		$display("config test done");
		bus(ADDR_CTRL2, 1'b1, 16'h0000);
		for (int p = 0; p < 4; p++) begin
			for (int s = 0; s < 8; s++) begin
				if (p == 3 && s == 7)
					continue;
				xfer(16'(32 + s * 4 + p), 16'($random(seed)));
				// Bit period in clk_sys cycles, twice the instruction clock count
				chk(period, 2 * (4 ** (3 - p)) * (8 - s));
			end
		end
		xfer(16'h047B, 16'($random(seed)));
		xfer(16'h067B, 16'($random(seed)));
		$display("divider test done");
		bus(ADDR_CTRL2, 1'b1, 16'hA000);
		d = 16'(rises);
		chk(32'(fs_o), 32'h0000_0000);
		bus(ADDR_DATA, 1'b1, 16'h5AC3);
		while (fs_o !== 1'b1) @(posedge clk_sys);
		chk(32'(rises), 32'(d));
		take(16'h5AC3, 16'hFFFF);
		bus(ADDR_CTRL2, 1'b1, 16'h0000);
		$display("frame test done");
		bus(ADDR_CTRL1, 1'b1, 16'h0022);
		bus(ADDR_DATA, 1'b1, 16'h0011);
		bus(ADDR_DATA, 1'b1, 16'h0022);
		rd(ADDR_STATUS, 16'h0002, 16'h0002);
		take(16'h0011, 16'h00FF);
		take(16'h0022, 16'h00FF);
		bus(ADDR_CTRL2, 1'b1, 16'h0001);
		for (int i = 0; i <= FIFO_DEPTH; i++) begin
			rd(ADDR_STATUS, 16'h0000, 16'h0002);
			bus(ADDR_DATA, 1'b1, 16'(160 + i));
		end
		// Eight queued plus one already in the shifter
		rd(ADDR_STATUS, 16'h0002, 16'h0002);
		do rd(ADDR_STATUS, 16'h0000, 16'h0000); while (r[B_ROV] !== 1'b1);
		rd(ADDR_STATUS, 16'h0041, 16'h0043);
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			rd(ADDR_DATA, 16'(160 + i), 16'h00FF);
			if (i == 0)
				rd(ADDR_STATUS, 16'h0000, 16'h0001);
		end
		rd(ADDR_STATUS, 16'h0020, 16'h0021);
		$display("buffer test done");
		report_and_stop();
	end
endmodule : test_scb_spi
